//--- hw/ipee_regs.svh
// Register offsets, field positions and reset values for the interrupt priority and enable block
`ifndef IPEE_REGS_SVH
`define IPEE_REGS_SVH

// Register addresses on the special-function bus
`define IPEE_PRIO_ADDR 8'hb8
`define IPEE_XEN_ADDR 8'he6

// Reset values
`define IPEE_PRIO_RESET 7'h00
`define IPEE_XEN_RESET 8'h00

// Priority register fields
`define IPEE_PRIO_UNUSED_BIT 7
`define IPEE_PRIO_W 7

// Extended enable fields
`define IPEE_XEN_T3_BIT 7
`define IPEE_XEN_RSVD_BIT 6
`define IPEE_XEN_CMP_BIT 5
`define IPEE_XEN_PCA_BIT 4
`define IPEE_XEN_CONV_BIT 3
`define IPEE_XEN_WIN_BIT 2
`define IPEE_XEN_PM_BIT 1
`define IPEE_XEN_SMB_BIT 0

// Source slots in the request vector, in vector order
`define IPEE_NUM_SRC 15
`define IPEE_SRC_EXT0 0
`define IPEE_SRC_T0 1
`define IPEE_SRC_EXT1 2
`define IPEE_SRC_T1 3
`define IPEE_SRC_UART 4
`define IPEE_SRC_T2 5
`define IPEE_SRC_SPI 6
`define IPEE_SRC_SMB 7
`define IPEE_SRC_PM 8
`define IPEE_SRC_WIN 9
`define IPEE_SRC_CONV 10
`define IPEE_SRC_PCA 11
`define IPEE_SRC_CMP 12
`define IPEE_SRC_RSVD 13
`define IPEE_SRC_T3 14

`endif

//--- hw/ipee_pkg.sv
// Types shared by the interrupt priority and enable block
`include "ipee_regs.svh"
`default_nettype none
package ipee_pkg;
	typedef logic [7:0] ipee_byte_t;
	typedef logic [2:0] ipee_bit_idx_t;
	typedef logic [`IPEE_NUM_SRC-1:0] ipee_src_vec_t;
endpackage
`default_nettype wire

//--- hw/ipee_req_gate.sv
// Per-source request gating with priority tagging, registered outputs
`default_nettype none
module ipee_req_gate #(
	parameter int NUM_SRC = 15
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Gating inputs
	input wire logic [NUM_SRC-1:0] pend_in,
	input wire logic [NUM_SRC-1:0] enable_in,
	input wire logic [NUM_SRC-1:0] prio_in,
	input wire logic global_in,
	// Gated requests
	output logic [NUM_SRC-1:0] req_out,
	output logic [NUM_SRC-1:0] high_out,
	output logic any_high_out,
	output logic any_low_out
);
	logic [NUM_SRC-1:0] nxt_req;
	logic [NUM_SRC-1:0] nxt_high;

	// One gate per source
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++)
		begin : gen_src
			assign nxt_req[g] = pend_in[g] & enable_in[g] & global_in;
			assign nxt_high[g] = nxt_req[g] & prio_in[g];
		end
	endgenerate

	// Register requests and their level summaries
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			req_out <= '0;
			high_out <= '0;
			any_high_out <= 1'b0;
			any_low_out <= 1'b0;
		end
		else
		begin
			req_out <= nxt_req;
			high_out <= nxt_high;
			any_high_out <= |nxt_high;
			any_low_out <= |(nxt_req & ~nxt_high);
		end
	end
endmodule
`default_nettype wire

//--- hw/ipee_top.sv
// Interrupt priority register, extended enable register and request gating
`include "ipee_regs.svh"
`default_nettype none
// Notes on behaviour
// - Priority bit 7 reads one, ignores writes
// - Priority bits 6..0 pick source level
// - Priority register at 0xB8, bit addressable
// - Enable bit 7 gates timer three flags
// - Enable bit 5 gates comparator edge flags
// - Enable bit 4 gates counter array requests
// - Enable bit 3 gates conversion done
// - Enable bit 2 gates window compare
// - Enable bit 1 gates port match
// - Enable bit 0 gates SMBus requests
// - Global enable low masks every source
module ipee_top (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Byte access on the special-function bus
	input wire ipee_pkg::ipee_byte_t sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire ipee_pkg::ipee_byte_t sfr_wdata_in,
	input wire logic sfr_rd_in,
	output ipee_pkg::ipee_byte_t sfr_rdata_out,
	output logic sfr_hit_out,
	// Single-bit access
	input wire ipee_pkg::ipee_byte_t bit_addr_in,
	input wire logic bit_wr_in,
	input wire logic bit_val_in,
	input wire logic bit_rd_in,
	output logic bit_rdata_out,
	// Enables and levels held outside this block
	input wire logic global_irq_enable_in,
	input wire logic [6:0] legacy_enable_in,
	input wire ipee_pkg::ipee_byte_t ext_priority_in,
	// Legacy pending flags
	input wire logic ext_input_zero_pend_in,
	input wire logic timer_zero_pend_in,
	input wire logic ext_input_one_pend_in,
	input wire logic timer_one_pend_in,
	input wire logic uart_pend_in,
	input wire logic timer_two_pend_in,
	input wire logic serial_periph_pend_in,
	// Extended pending flags
	input wire logic timer_three_low_overflow_in,
	input wire logic timer_three_high_overflow_in,
	input wire logic comparator_rise_flag_in,
	input wire logic comparator_fall_flag_in,
	input wire logic counter_array_pend_in,
	input wire logic conversion_done_flag_in,
	input wire logic window_compare_flag_in,
	input wire logic port_match_in,
	input wire logic smbus_pend_in,
	// Requests to the core
	output ipee_pkg::ipee_src_vec_t irq_req_out,
	output ipee_pkg::ipee_src_vec_t irq_high_out,
	output logic any_high_req_out,
	output logic any_low_req_out
);
	import ipee_pkg::*;

	//--------------------------------------------------------------
	// Register storage
	//--------------------------------------------------------------
	logic [`IPEE_PRIO_W-1:0] prio_ff;
	ipee_byte_t xen_ff;
	ipee_byte_t prio_view;
	ipee_byte_t nxt_rdata;
	logic hit_prio;
	logic hit_xen;
	logic bit_hit;
	ipee_bit_idx_t bit_idx;
	logic nxt_bit_rdata;
	ipee_src_vec_t pend_vec;
	ipee_src_vec_t en_vec;
	ipee_src_vec_t prio_vec;

	assign prio_view = {1'b1, prio_ff};

	assign hit_prio = (sfr_addr_in == `IPEE_PRIO_ADDR);
	assign hit_xen = (sfr_addr_in == `IPEE_XEN_ADDR);
	assign sfr_hit_out = hit_prio | hit_xen;

	// bit address lands on the priority byte
	assign bit_hit = (bit_addr_in[7:3] == 5'(`IPEE_PRIO_ADDR >> 3));
	assign bit_idx = bit_addr_in[2:0];

	//--------------------------------------------------------------
	// Register writes
	//--------------------------------------------------------------
	// Priority register: byte write, else single-bit write
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			prio_ff <= `IPEE_PRIO_RESET;
		end
		else if (sfr_wr_in && hit_prio)
		begin
			prio_ff <= sfr_wdata_in[`IPEE_PRIO_W-1:0];
		end
		else if (bit_wr_in && bit_hit && bit_idx != 3'(`IPEE_PRIO_UNUSED_BIT))
		begin
			prio_ff[bit_idx] <= bit_val_in;
		end
	end

	// Extended enable: byte access only; reserved bit is kept as written
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			xen_ff <= `IPEE_XEN_RESET;
		end
		else if (sfr_wr_in && hit_xen)
		begin
			xen_ff <= sfr_wdata_in;
		end
	end

	//--------------------------------------------------------------
	// Register reads
	//--------------------------------------------------------------
	// Byte read mux, unmapped addresses read zero
	always_comb
	begin
		nxt_rdata = 8'h00;
		if (hit_prio)
		begin
			nxt_rdata = prio_view;
		end
		else if (hit_xen)
		begin
			nxt_rdata = xen_ff;
		end
	end

	// Single-bit test read
	assign nxt_bit_rdata = bit_hit ? prio_view[bit_idx] : 1'b0;

	// Read data held until the next read
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			sfr_rdata_out <= 8'h00;
		end
		else if (sfr_rd_in)
		begin
			sfr_rdata_out <= nxt_rdata;
		end
	end

	// Bit read data held until the next bit read
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			bit_rdata_out <= 1'b0;
		end
		else if (bit_rd_in)
		begin
			bit_rdata_out <= nxt_bit_rdata;
		end
	end

	//--------------------------------------------------------------
	// Source vectors
	//--------------------------------------------------------------
	// Pending flags per slot; paired flags merge into one request
	always_comb
	begin
		pend_vec = '0;
		pend_vec[`IPEE_SRC_EXT0] = ext_input_zero_pend_in;
		pend_vec[`IPEE_SRC_T0] = timer_zero_pend_in;
		pend_vec[`IPEE_SRC_EXT1] = ext_input_one_pend_in;
		pend_vec[`IPEE_SRC_T1] = timer_one_pend_in;
		pend_vec[`IPEE_SRC_UART] = uart_pend_in;
		pend_vec[`IPEE_SRC_T2] = timer_two_pend_in;
		pend_vec[`IPEE_SRC_SPI] = serial_periph_pend_in;
		pend_vec[`IPEE_SRC_SMB] = smbus_pend_in;
		pend_vec[`IPEE_SRC_PM] = port_match_in;
		pend_vec[`IPEE_SRC_WIN] = window_compare_flag_in;
		pend_vec[`IPEE_SRC_CONV] = conversion_done_flag_in;
		pend_vec[`IPEE_SRC_PCA] = counter_array_pend_in;
		pend_vec[`IPEE_SRC_CMP] = comparator_rise_flag_in | comparator_fall_flag_in;
		pend_vec[`IPEE_SRC_T3] = timer_three_low_overflow_in | timer_three_high_overflow_in;
	end

	// Enable bits per slot; the reserved slot never fires
	always_comb
	begin
		en_vec = '0;
		en_vec[`IPEE_SRC_SPI:`IPEE_SRC_EXT0] = legacy_enable_in;
		en_vec[`IPEE_SRC_SMB] = xen_ff[`IPEE_XEN_SMB_BIT];
		en_vec[`IPEE_SRC_PM] = xen_ff[`IPEE_XEN_PM_BIT];
		en_vec[`IPEE_SRC_WIN] = xen_ff[`IPEE_XEN_WIN_BIT];
		en_vec[`IPEE_SRC_CONV] = xen_ff[`IPEE_XEN_CONV_BIT];
		en_vec[`IPEE_SRC_PCA] = xen_ff[`IPEE_XEN_PCA_BIT];
		en_vec[`IPEE_SRC_CMP] = xen_ff[`IPEE_XEN_CMP_BIT];
		en_vec[`IPEE_SRC_T3] = xen_ff[`IPEE_XEN_T3_BIT];
	end

	// Priority levels per slot; one selects high for every source
	always_comb
	begin
		prio_vec = '0;
		prio_vec[`IPEE_SRC_SPI:`IPEE_SRC_EXT0] = prio_ff;
		prio_vec[`IPEE_SRC_SMB] = ext_priority_in[`IPEE_XEN_SMB_BIT];
		prio_vec[`IPEE_SRC_PM] = ext_priority_in[`IPEE_XEN_PM_BIT];
		prio_vec[`IPEE_SRC_WIN] = ext_priority_in[`IPEE_XEN_WIN_BIT];
		prio_vec[`IPEE_SRC_CONV] = ext_priority_in[`IPEE_XEN_CONV_BIT];
		prio_vec[`IPEE_SRC_PCA] = ext_priority_in[`IPEE_XEN_PCA_BIT];
		prio_vec[`IPEE_SRC_CMP] = ext_priority_in[`IPEE_XEN_CMP_BIT];
		prio_vec[`IPEE_SRC_T3] = ext_priority_in[`IPEE_XEN_T3_BIT];
	end

	//--------------------------------------------------------------
	// Request gating
	//--------------------------------------------------------------
	// global enable overrides masks
	ipee_req_gate #(
		.NUM_SRC(`IPEE_NUM_SRC)
	) u_gate (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.pend_in(pend_vec),
		.enable_in(en_vec),
		.prio_in(prio_vec),
		.global_in(global_irq_enable_in),
		.req_out(irq_req_out),
		.high_out(irq_high_out),
		.any_high_out(any_high_req_out),
		.any_low_out(any_low_req_out)
	);

	//--------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	property p_unused_reads_one;
		sfr_rd_in && sfr_addr_in == `IPEE_PRIO_ADDR |=> sfr_rdata_out[7];
	endproperty
	a_unused_reads_one: assert property (p_unused_reads_one) else $error("Priority bit 7 read as zero");
	property p_unused_bit_write;
		bit_wr_in && bit_hit && bit_idx == 3'd7 && !(sfr_wr_in && hit_prio) |=> $stable(prio_ff);
	endproperty
	a_unused_bit_write: assert property (p_unused_bit_write) else $error("Bit 7 write changed priority");
	property p_prio_byte_write;
		sfr_wr_in && hit_prio ##1 sfr_rd_in && hit_prio && !bit_wr_in
			|=> sfr_rdata_out == {1'b1, $past(sfr_wdata_in[6:0], 2)};
	endproperty
	a_prio_byte_write: assert property (p_prio_byte_write) else $error("Priority byte readback wrong");
	property p_bit_write;
		bit_wr_in && bit_hit && bit_idx != 3'd7 && !(sfr_wr_in && hit_prio)
			|=> prio_ff[$past(bit_idx)] == $past(bit_val_in);
	endproperty
	a_bit_write: assert property (p_bit_write) else $error("Single-bit write lost");
	property p_t3_gate;
		global_irq_enable_in && (timer_three_low_overflow_in || timer_three_high_overflow_in)
			|=> irq_req_out[`IPEE_SRC_T3] == $past(xen_ff[7]);
	endproperty
	a_t3_gate: assert property (p_t3_gate) else $error("Timer three request gating wrong");
	property p_cmp_gate;
		global_irq_enable_in && comparator_fall_flag_in |=> irq_req_out[`IPEE_SRC_CMP] == $past(xen_ff[5]);
	endproperty
	a_cmp_gate: assert property (p_cmp_gate) else $error("Comparator request gating wrong");
	property p_pca_mask;
		!xen_ff[4] |=> !irq_req_out[`IPEE_SRC_PCA];
	endproperty
	a_pca_mask: assert property (p_pca_mask) else $error("Counter array request not masked");
	property p_conv_gate;
		global_irq_enable_in && xen_ff[3] && conversion_done_flag_in |=> irq_req_out[`IPEE_SRC_CONV];
	endproperty
	a_conv_gate: assert property (p_conv_gate) else $error("Conversion done request missing");
	property p_win_mask;
		!xen_ff[2] |=> !irq_req_out[`IPEE_SRC_WIN];
	endproperty
	a_win_mask: assert property (p_win_mask) else $error("Window compare request not masked");
	property p_pm_gate;
		global_irq_enable_in && xen_ff[1] && port_match_in |=> irq_req_out[`IPEE_SRC_PM];
	endproperty
	a_pm_gate: assert property (p_pm_gate) else $error("Port match request missing");
	property p_smb_gate;
		global_irq_enable_in && smbus_pend_in |=> irq_req_out[`IPEE_SRC_SMB] == $past(xen_ff[0]);
	endproperty
	a_smb_gate: assert property (p_smb_gate) else $error("SMBus request gating wrong");
	property p_global_off;
		!global_irq_enable_in [*2] |=> irq_req_out == '0 && !any_high_req_out && !any_low_req_out;
	endproperty
	a_global_off: assert property (p_global_off) else $error("Request while globally disabled");
	property p_t1_high;
		global_irq_enable_in && legacy_enable_in[3] && timer_one_pend_in && prio_ff[3]
			|=> irq_high_out[`IPEE_SRC_T1] && any_high_req_out;
	endproperty
	a_t1_high: assert property (p_t1_high) else $error("Timer one not high priority");
	property p_req_cause;
		irq_req_out[`IPEE_SRC_T0] |-> $past(timer_zero_pend_in && legacy_enable_in[1] && global_irq_enable_in)
			&& irq_high_out[`IPEE_SRC_T0] == $past(prio_ff[1]);
	endproperty
	a_req_cause: assert property (p_req_cause) else $error("Request without its cause");

	// Main scenarios
	c_t3_high: cover property (irq_high_out[`IPEE_SRC_T3]);
	c_bit_then_read: cover property (bit_wr_in && bit_hit ##1 bit_rd_in && bit_hit);
	c_both_levels: cover property (any_high_req_out && any_low_req_out);
	c_xen_write: cover property (sfr_wr_in && hit_xen ##1 sfr_rd_in && hit_xen);
endmodule
`default_nettype wire

//--- verification/ipee_src_model.sv
// Pending-flag model of the peripherals that feed the request inputs of the block
`default_nettype none
module ipee_src_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Flag pattern commanded by the core side
	input wire logic [15:0] pattern_in,
	// Pending flags towards the block
	output logic [15:0] flags_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Flags settle one clock after the command, as a real peripheral register would
	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
			flags_out <= 16'h0000;
		else
			flags_out <= pattern_in;
	end
endmodule
`default_nettype wire

//--- verification/test_ipee_top.sv
// Self-checking bench for the interrupt priority and extended enable block
`include "ipee_regs.svh"
`default_nettype none
module test_ipee_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ipee_pkg::*;
	logic clk_in = 1'b0, reset_in = 1'b1;
	logic sfr_wr_in = 1'b0, sfr_rd_in = 1'b0, bit_wr_in = 1'b0, bit_val_in = 1'b0, bit_rd_in = 1'b0;
	logic global_irq_enable_in = 1'b0;
	ipee_byte_t sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, bit_addr_in = 8'h00, ext_priority_in = 8'h00;
	logic [6:0] legacy_enable_in = 7'h00, prio_m = 7'h00;
	logic [15:0] pattern = 16'h0000, flags;
	ipee_byte_t sfr_rdata_out, xen_m = 8'h00;
	logic sfr_hit_out, bit_rdata_out, any_high_req_out, any_low_req_out;
	ipee_src_vec_t irq_req_out, irq_high_out;
	int n_errors = 0, total_checks = 0, cycles = 0;
	logic [31:0] r, s;

	// Free-running system clock, 40 ns period
	always #20 clk_in = ~clk_in;

	ipee_src_model ipee_src_model_inst (.clk_in(clk_in), .reset_in(reset_in), .pattern_in(pattern), .flags_out(flags));

	ipee_top ipee_top_inst (.clk_in(clk_in), .reset_in(reset_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
		.sfr_wdata_in(sfr_wdata_in), .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out), .sfr_hit_out(sfr_hit_out),
		.bit_addr_in(bit_addr_in), .bit_wr_in(bit_wr_in), .bit_val_in(bit_val_in), .bit_rd_in(bit_rd_in),
		.bit_rdata_out(bit_rdata_out), .global_irq_enable_in(global_irq_enable_in),
		.legacy_enable_in(legacy_enable_in), .ext_priority_in(ext_priority_in),
		.ext_input_zero_pend_in(flags[0]), .timer_zero_pend_in(flags[1]), .ext_input_one_pend_in(flags[2]),
		.timer_one_pend_in(flags[3]), .uart_pend_in(flags[4]), .timer_two_pend_in(flags[5]),
		.serial_periph_pend_in(flags[6]), .smbus_pend_in(flags[7]), .port_match_in(flags[8]),
		.window_compare_flag_in(flags[9]), .conversion_done_flag_in(flags[10]), .counter_array_pend_in(flags[11]),
		.comparator_rise_flag_in(flags[12]), .comparator_fall_flag_in(flags[13]),
		.timer_three_low_overflow_in(flags[14]), .timer_three_high_overflow_in(flags[15]),
		.irq_req_out(irq_req_out), .irq_high_out(irq_high_out), .any_high_req_out(any_high_req_out),
		.any_low_req_out(any_low_req_out));

	// Verdict and end of run
	task automatic end_sim;
		if (n_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Comparisons, one per kind of result
	task automatic cmp_byte(input ipee_byte_t g, input ipee_byte_t e);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cmp_bit(input logic g, input logic e);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cmp_vec(input ipee_src_vec_t g, input ipee_src_vec_t e);
		total_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Expected gated requests from flags, enables and global enable
	function automatic ipee_src_vec_t exp_req(input logic [15:0] p);
		ipee_src_vec_t v;
		v = '0;
		v[6:0] = p[6:0] & legacy_enable_in;
		v[11:7] = p[11:7] & xen_m[4:0];
		v[12] = (p[12] | p[13]) & xen_m[5];
		v[14] = (p[14] | p[15]) & xen_m[7];
		return global_irq_enable_in ? v : '0;
	endfunction
	function automatic ipee_src_vec_t exp_high(input ipee_src_vec_t v);
		return v & {ext_priority_in[7], 1'b0, ext_priority_in[5:0], prio_m};
	endfunction
	function automatic logic bit_exp(input ipee_byte_t a);
		if (a == 8'hbf)
			return 1'b1;
		if (a >= 8'hb8 && a < 8'hbf)
			return prio_m[a[2:0]];
		return 1'b0;
	endfunction

	// Byte and single-bit accesses, strobe held for one taking edge
	task automatic byte_wr(input ipee_byte_t a, input ipee_byte_t d);
		@(posedge clk_in);
		sfr_addr_in <= a;
		sfr_wdata_in <= d;
		sfr_wr_in <= 1'b1;
		@(posedge clk_in);
		sfr_wr_in <= 1'b0;
		if (a == `IPEE_PRIO_ADDR)
			prio_m = d[6:0];
		if (a == `IPEE_XEN_ADDR)
			xen_m = d;
	endtask
	task automatic byte_rd(input ipee_byte_t a, input ipee_byte_t e);
		@(posedge clk_in);
		sfr_addr_in <= a;
		sfr_rd_in <= 1'b1;
		@(posedge clk_in);
		sfr_rd_in <= 1'b0;
		@(negedge clk_in);
		cmp_byte(sfr_rdata_out, e);
		cmp_bit(sfr_hit_out, a == `IPEE_PRIO_ADDR || a == `IPEE_XEN_ADDR);
	endtask
	task automatic bit_wr(input ipee_byte_t a, input logic v);
		@(posedge clk_in);
		bit_addr_in <= a;
		bit_val_in <= v;
		bit_wr_in <= 1'b1;
		@(posedge clk_in);
		bit_wr_in <= 1'b0;
		if (a >= 8'hb8 && a < 8'hbf)
			prio_m[a[2:0]] = v;
	endtask
	task automatic bit_rd(input ipee_byte_t a);
		@(posedge clk_in);
		bit_addr_in <= a;
		bit_rd_in <= 1'b1;
		@(posedge clk_in);
		bit_rd_in <= 1'b0;
		@(negedge clk_in);
		cmp_bit(bit_rdata_out, bit_exp(a));
	endtask

	// Byte write then read back on the very next cycle, no idle gap
	task automatic wr_rd(input ipee_byte_t a, input ipee_byte_t d);
		@(posedge clk_in);
		sfr_addr_in <= a;
		sfr_wdata_in <= d;
		sfr_wr_in <= 1'b1;
		@(posedge clk_in);
		sfr_wr_in <= 1'b0;
		sfr_rd_in <= 1'b1;
		if (a == `IPEE_PRIO_ADDR)
			prio_m = d[6:0];
		if (a == `IPEE_XEN_ADDR)
			xen_m = d;
		@(posedge clk_in);
		sfr_rd_in <= 1'b0;
		@(negedge clk_in);
		cmp_byte(sfr_rdata_out, (a == `IPEE_PRIO_ADDR) ? {1'b1, prio_m} : xen_m);
	endtask

	// Single-bit write then bit read on the very next cycle
	task automatic bit_wr_rd(input ipee_byte_t a, input logic v);
		@(posedge clk_in);
		bit_addr_in <= a;
		bit_val_in <= v;
		bit_wr_in <= 1'b1;
		@(posedge clk_in);
		bit_wr_in <= 1'b0;
		bit_rd_in <= 1'b1;
		if (a >= 8'hb8 && a < 8'hbf)
			prio_m[a[2:0]] = v;
		@(posedge clk_in);
		bit_rd_in <= 1'b0;
		@(negedge clk_in);
		cmp_bit(bit_rdata_out, bit_exp(a));
	endtask

	// Apply flags and masks, then compare all request outputs once settled
	task automatic check_src(input logic [15:0] p, input logic [6:0] le, input ipee_byte_t ep, input logic g);
		ipee_src_vec_t e;
		@(posedge clk_in);
		pattern <= p;
		legacy_enable_in <= le;
		ext_priority_in <= ep;
		global_irq_enable_in <= g;
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		e = exp_req(p);
		cmp_vec(irq_req_out, e);
		cmp_vec(irq_high_out, exp_high(e));
		cmp_bit(any_high_req_out, |exp_high(e));
		cmp_bit(any_low_req_out, |(e & ~exp_high(e)));
	endtask

	// Hang guard
	always @(posedge clk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_errors++;
			end_sim;
		end
	end

	// Main sequence
	initial
	begin
		r = $urandom(5186);
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		byte_rd(`IPEE_PRIO_ADDR, 8'h80);
		byte_rd(`IPEE_XEN_ADDR, 8'h00);
		byte_rd(8'ha8, 8'h00);
		byte_wr(`IPEE_PRIO_ADDR, 8'h08);
		byte_rd(`IPEE_PRIO_ADDR, 8'h88);
		bit_wr(8'hbf, 1'b0);
		bit_rd(8'hbf);
		bit_rd(8'hbb);
		check_src(16'h0008, 7'h08, 8'h00, 1'b1);
		bit_wr(8'hbb, 1'b0);
		bit_rd(8'hbb);
		// Each extended enable alone, every flag pending
		for (int i = 0; i < 8; i++)
		begin
			if (i != 6)
			begin
				byte_wr(`IPEE_XEN_ADDR, 8'h01 << i);
				check_src(16'hffff, 7'h00, 8'hff, 1'b1);
			end
		end
		byte_wr(`IPEE_XEN_ADDR, 8'ha0);
		check_src(16'h8000, 7'h00, 8'h80, 1'b1);
		check_src(16'h2000, 7'h00, 8'h00, 1'b1);
		check_src(16'hffff, 7'h7f, 8'hff, 1'b0);
		for (int k = 0; k < 200; k++)
		begin
			r = $urandom;
			s = $urandom;
			byte_wr(`IPEE_PRIO_ADDR, r[7:0]);
			byte_rd(`IPEE_PRIO_ADDR, {1'b1, prio_m});
			bit_wr({4'hb, r[11:8]}, r[12]);
			bit_rd({4'hb, r[27:24]});
			byte_wr(`IPEE_XEN_ADDR, r[23:16] & 8'hbf);
			byte_rd(`IPEE_XEN_ADDR, xen_m);
			check_src(s[15:0], s[22:16], s[31:24], r[31] | r[30]);
			wr_rd(`IPEE_PRIO_ADDR, s[7:0] ^ r[7:0]);
			wr_rd(`IPEE_XEN_ADDR, s[15:8] & 8'hbf);
			bit_wr_rd({4'hb, s[19:16]}, s[20]);
		end
		// Reset in mid-run clears both registers
		@(posedge clk_in);
		reset_in <= 1'b1;
		@(posedge clk_in);
		reset_in <= 1'b0;
		prio_m = 7'h00;
		xen_m = 8'h00;
		byte_rd(`IPEE_PRIO_ADDR, 8'h80);
		byte_rd(`IPEE_XEN_ADDR, 8'h00);
		end_sim;
	end
endmodule
`default_nettype wire
